// file: inc/mhsp_pkg.sv
// Package of constants for the mesh host serial port
// Function
// - Drive clear-to-send low while more host bytes can be accepted, else high.
// - Config-enable low: every received byte goes to the command path.
// - Command-set parameters are kept in storage surviving power cycles.
// - Frame sent data with preamble, start marker, routing and trailing CRC.
// - Check each received packet for own destination address and good CRC.
// - Acknowledge a matching, error-free packet before forwarding it.
// - A gateway starts in transparent mode after reset.
// - Transparent: routers output gateway data unmodified on the serial port.
// - Router data reaches the gateway and leaves its serial port unaltered.
// - Software flow control: send Xon instead of lowering clear-to-send.
// - Start transmission when buffer is full or the character gap times out.
// - Packet mode: gateway serial data carries address and command bytes; the frame takes them from REG_TX_DEST and REG_TX_CMD instead.
// - Packet mode: commands go to one device, a group, or broadcast.
// - Header-stripping mode outputs payload only, otherwise as packet mode.
// - Provide a 256-byte serial input buffer.
// - Deassert clear-to-send a configurable margin before full, default 18.
// - After successful transmission, lower clear-to-send or send Xon again.
package mhsp_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD = 115_200;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int BUF_DEPTH = 256;
  localparam int MARGIN_RST = 18;
  localparam int TIMEOUT_MS = 4;
  localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int PREAMBLE_LEN = 4;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_MARGIN = 4'h2;
  localparam logic [3:0] REG_OWN_ADDR = 4'h3;
  localparam logic [3:0] REG_GROUP = 4'h4;
  localparam logic [3:0] REG_TX_DEST = 4'h5;
  localparam logic [3:0] REG_TX_CMD = 4'h6;
  localparam logic [3:0] REG_RF_RX = 4'h7;
  localparam logic [3:0] REG_RF_RXEND = 4'h8;
  localparam logic [3:0] REG_RF_TX = 4'h9;
  localparam logic [3:0] REG_CFG_RD = 4'hA;
  localparam logic [3:0] REG_NV_SAVE = 4'hB;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_XONXOFF_BIT = 2;
  localparam int CTRL_GATEWAY_BIT = 3;
  localparam logic [7:0] CTRL_RST = 8'h08;
  // Status register fields
  localparam int STAT_ACK_BIT = 0;
  localparam int STAT_BAD_BIT = 1;
  localparam int STAT_TXBUSY_BIT = 2;
  localparam int STAT_CFGAV_BIT = 3;
  // Characters and frame bytes
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SOF_BYTE = 8'h7E;
  localparam logic [7:0] BCAST_ADDR = 8'hFF;
  localparam logic [7:0] ACK_BYTE = 8'h06;
  typedef enum logic [1:0] {
    MHSP_MODE_TRANSP = 2'b00,
    MHSP_MODE_PACKET = 2'b01,
    MHSP_MODE_STRIP = 2'b10
  } mhsp_mode_e;
  typedef enum logic [2:0] {
    MHSP_TX_IDLE = 3'b000,
    MHSP_TX_PRE = 3'b001,
    MHSP_TX_SOF = 3'b010,
    MHSP_TX_DEST = 3'b011,
    MHSP_TX_CMD = 3'b100,
    MHSP_TX_DATA = 3'b101,
    MHSP_TX_CRC = 3'b110,
    MHSP_TX_WAIT = 3'b111
  } mhsp_tx_e;
  // CRC-8 step, polynomial x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    end
    return r;
  endfunction
endpackage

// file: src/mhsp_uart.sv
// Serial byte transmitter and receiver of the host port
`timescale 1ns/1ps
`default_nettype none
module mhsp_uart #(
  parameter int BIT_CYC = mhsp_pkg::BIT_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rxd_i,
  output logic [7:0] rx_data_o,
  output logic rx_stb_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_stb_i,
  output logic tx_busy_o,
  output logic txd_o
);
  import mhsp_pkg::*;
  initial begin
    if (BIT_CYC < 4 || BIT_CYC > 65535) $error("BIT_CYC out of range");
  end
  logic rx_s1_r, rx_s2_r;
  logic [15:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_sh_r;
  logic rx_act_r;
  logic [15:0] tx_cnt_r;
  logic [3:0] tx_bit_r;
  logic [9:0] tx_sh_r;
  // Two-stage synchroniser on the pin
  always_ff @(posedge clk_i) begin
    rx_s1_r <= reset_i ? 1'b1 : rxd_i;
    rx_s2_r <= reset_i ? 1'b1 : rx_s1_r;
  end
  // Receiver samples mid-bit; strobe fires at the stop bit sample
  always_ff @(posedge clk_i) begin
    rx_stb_o <= 1'b0;
    if (reset_i) begin
      rx_act_r <= 1'b0;
      rx_cnt_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      rx_data_o <= '0;
    end else if (!rx_act_r) begin
      if (!rx_s2_r) begin
        rx_act_r <= 1'b1;
        rx_cnt_r <= 16'(BIT_CYC / 2);
        rx_bit_r <= '0;
      end
    end else if (rx_cnt_r != 0) begin
      rx_cnt_r <= rx_cnt_r - 16'h0001;
    end else begin
      rx_cnt_r <= 16'(BIT_CYC - 1);
      rx_sh_r <= {rx_s2_r, rx_sh_r[8:1]};
      rx_bit_r <= rx_bit_r + 4'h1;
      if (rx_bit_r == 4'h9) begin
        rx_act_r <= 1'b0;
        rx_data_o <= rx_sh_r[8:1];
        rx_stb_o <= rx_s2_r;
      end
    end
  end
  // Transmitter: start, eight data bits LSB first, stop
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_sh_r <= '1;
      tx_bit_r <= '0;
      tx_cnt_r <= '0;
      tx_busy_o <= 1'b0;
      txd_o <= 1'b1;
    end else if (!tx_busy_o) begin
      txd_o <= 1'b1;
      if (tx_stb_i) begin
        tx_sh_r <= {1'b1, tx_data_i, 1'b0};
        tx_busy_o <= 1'b1;
        tx_bit_r <= '0;
        tx_cnt_r <= '0;
      end
    end else if (tx_cnt_r != 0) begin
      tx_cnt_r <= tx_cnt_r - 16'h0001;
    end else if (tx_bit_r == 4'hA) begin
      tx_busy_o <= 1'b0;
    end else begin
      txd_o <= tx_sh_r[0];
      tx_sh_r <= {1'b1, tx_sh_r[9:1]};
      tx_bit_r <= tx_bit_r + 4'h1;
      tx_cnt_r <= 16'(BIT_CYC - 1);
    end
  end
endmodule
`default_nettype wire

// file: src/mhsp_top.sv
// Host serial port of the mesh module: buffer, flow control, framing, delivery
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module mhsp_top #(
  parameter int BUF_DEPTH = mhsp_pkg::BUF_DEPTH,
  parameter int TIMEOUT_CYC = mhsp_pkg::TIMEOUT_CYC,
  parameter int BIT_CYC = mhsp_pkg::BIT_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic cts_n_o,
  input wire logic config_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic rf_tx_valid_o,
  output logic [7:0] rf_tx_data_o,
  output logic rf_tx_last_o,
  output logic [7:0] nv_addr_o,
  output logic [7:0] nv_data_o,
  output logic nv_we_o
);
  import mhsp_pkg::*;
  localparam int AW = $clog2(BUF_DEPTH);
  initial begin
    if (BUF_DEPTH != 256) $error("BUF_DEPTH must be 256");
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 16777215) $error("TIMEOUT_CYC out of range");
  end
  // ----------------------------------------------------------------
  // Registers and serial engine
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r, margin_r, own_r, group_r, dest_r, cmd_r;
  logic [7:0] stat_r;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic [23:0] idle_r;
  logic tx_go_r;
  mhsp_tx_e fsm_r;
  logic [2:0] pre_r;
  logic [7:0] crc_r;
  logic [AW:0] left_r;
  logic [7:0] cfg_cmd_r, cfg_val_r;
  logic cfg_phase_r, cfg_av_r, cfg_s1_r, cfg_s2_r;
  logic [7:0] rxp_buf [16];
  logic [3:0] rxp_cnt_r;
  logic [7:0] rxp_crc_r;
  logic [7:0] out_q [16];
  logic [4:0] oq_len_r, oq_rd_r;
  logic [7:0] uart_rx;
  logic uart_stb, uart_busy;
  logic [7:0] utx_r;
  logic utx_stb_r;
  logic xon_sent_r, xon_want_r;
  mhsp_uart #(.BIT_CYC(BIT_CYC)) u_uart (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .rxd_i(rxd_i),
    .rx_data_o(uart_rx),
    .rx_stb_o(uart_stb),
    .tx_data_i(utx_r),
    .tx_stb_i(utx_stb_r),
    .tx_busy_o(uart_busy),
    .txd_o(txd_o)
  );
  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire mhsp_mode_e mode = mhsp_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
  wire sw_flow = ctrl_r[CTRL_XONXOFF_BIT];
  wire cfg_mode = ~cfg_s2_r;
  // Ready while fill sits below capacity less the margin and no frame is in transmission
  wire [AW:0] thresh = (AW+1)'(BUF_DEPTH) - (AW+1)'(margin_r);
  wire accept = (cnt_r < thresh) && !tx_go_r;
  wire buf_full = cnt_r == (AW+1)'(BUF_DEPTH);
  wire data_in = uart_stb && !cfg_mode && accept && !buf_full;
  wire timed_out = (idle_r == 24'(TIMEOUT_CYC)) && (cnt_r != 0);
  wire tx_pop = (fsm_r == MHSP_TX_DATA) && (left_r != 0);
  wire wr_rf_rx = wr_i && (addr_i == REG_RF_RX);
  wire wr_rf_end = wr_i && (addr_i == REG_RF_RXEND);
  wire [7:0] rxp_dest = rxp_buf[0];
  wire addr_ok = (rxp_dest == own_r) || (rxp_dest == group_r) || (rxp_dest == BCAST_ADDR);
  wire crc_ok = (rxp_crc_r == 8'h00) && (rxp_cnt_r > 4'h1);
  wire rx_good = wr_rf_end && addr_ok && crc_ok;
  wire oq_busy = oq_rd_r != oq_len_r;
  // Config pin is asynchronous: two stages before any logic reads it
  always_ff @(posedge clk_i) begin
    cfg_s1_r <= reset_i | config_n_i;
    cfg_s2_r <= reset_i | cfg_s1_r;
  end
  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Mode, margin and addresses; gateway resets to transparent
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_r <= CTRL_RST;
      margin_r <= 8'(MARGIN_RST);
      own_r <= 8'h01;
      group_r <= 8'hFE;
      dest_r <= BCAST_ADDR;
      cmd_r <= 8'h00;
    end else if (wr_i) begin
      case (addr_i)
        REG_CTRL: ctrl_r <= wdata_i;
        REG_MARGIN: margin_r <= wdata_i;
        REG_OWN_ADDR: own_r <= wdata_i;
        REG_GROUP: group_r <= wdata_i;
        REG_TX_DEST: dest_r <= wdata_i;
        REG_TX_CMD: cmd_r <= wdata_i;
        default: ;
      endcase
    end
  end
  // Read data stands in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i || !rd_i) begin
      rdata_o <= 8'h00;
    end else begin
      case (addr_i)
        REG_CTRL: rdata_o <= ctrl_r;
        REG_STAT: rdata_o <= stat_r;
        REG_MARGIN: rdata_o <= margin_r;
        REG_OWN_ADDR: rdata_o <= own_r;
        REG_GROUP: rdata_o <= group_r;
        REG_TX_DEST: rdata_o <= dest_r;
        REG_TX_CMD: rdata_o <= cmd_r;
        REG_CFG_RD: rdata_o <= cfg_cmd_r;
        REG_NV_SAVE: rdata_o <= cfg_val_r;
        default: rdata_o <= 8'h00;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Input buffer and character timeout
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (data_in) begin
      buf_mem[wp_r] <= uart_rx;
    end
  end
  // Fill count, pointers; gap timer restarts on each stop bit outside config mode
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      idle_r <= '0;
    end else begin
      if (data_in) wp_r <= wp_r + AW'(1);
      if (tx_pop) rp_r <= rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(data_in) - (AW+1)'(tx_pop);
      if (uart_stb && !cfg_mode) begin
        idle_r <= '0;
      end else if (idle_r != 24'(TIMEOUT_CYC)) begin
        idle_r <= idle_r + 24'h00_0001;
      end
    end
  end
  // ----------------------------------------------------------------
  // Outgoing radio frame
  // ----------------------------------------------------------------
  // Framing: preamble, start marker, routing, payload, CRC, then wait
  always_ff @(posedge clk_i) begin
    rf_tx_last_o <= 1'b0;
    if (reset_i) begin
      fsm_r <= MHSP_TX_IDLE;
      tx_go_r <= 1'b0;
      rf_tx_valid_o <= 1'b0;
      rf_tx_data_o <= 8'h00;
      pre_r <= '0;
      crc_r <= '0;
      left_r <= '0;
    end else begin
      rf_tx_valid_o <= 1'b0;
      case (fsm_r)
        MHSP_TX_IDLE: if (!cfg_mode && (buf_full || timed_out)) begin
          fsm_r <= MHSP_TX_PRE;
          tx_go_r <= 1'b1;
          left_r <= cnt_r;
          pre_r <= '0;
        end
        MHSP_TX_PRE: begin
          rf_tx_valid_o <= 1'b1;
          rf_tx_data_o <= PREAMBLE_BYTE;
          pre_r <= pre_r + 3'h1;
          if (pre_r == 3'(PREAMBLE_LEN - 1)) fsm_r <= MHSP_TX_SOF;
        end
        MHSP_TX_SOF: begin
          rf_tx_valid_o <= 1'b1;
          rf_tx_data_o <= SOF_BYTE;
          crc_r <= 8'h00;
          fsm_r <= MHSP_TX_DEST;
        end
        MHSP_TX_DEST: begin
          rf_tx_valid_o <= 1'b1;
          rf_tx_data_o <= (mode == MHSP_MODE_TRANSP) ? BCAST_ADDR : dest_r;
          crc_r <= crc8(8'h00, (mode == MHSP_MODE_TRANSP) ? BCAST_ADDR : dest_r);
          fsm_r <= MHSP_TX_CMD;
        end
        MHSP_TX_CMD: begin
          rf_tx_valid_o <= 1'b1;
          rf_tx_data_o <= cmd_r;
          crc_r <= crc8(crc_r, cmd_r);
          fsm_r <= MHSP_TX_DATA;
        end
        MHSP_TX_DATA: if (left_r != 0) begin
          rf_tx_valid_o <= 1'b1;
          rf_tx_data_o <= buf_mem[rp_r];
          crc_r <= crc8(crc_r, buf_mem[rp_r]);
          left_r <= left_r - (AW+1)'(1);
        end else begin
          fsm_r <= MHSP_TX_CRC;
        end
        MHSP_TX_CRC: begin
          rf_tx_valid_o <= 1'b1;
          rf_tx_last_o <= 1'b1;
          rf_tx_data_o <= crc_r;
          fsm_r <= MHSP_TX_WAIT;
        end
        MHSP_TX_WAIT: if (wr_i && addr_i == REG_RF_TX) begin
          fsm_r <= MHSP_TX_IDLE;
          tx_go_r <= 1'b0;
        end
        default: fsm_r <= MHSP_TX_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Configuration path
  // ----------------------------------------------------------------
  // Bytes in config mode pair as command then value; pair goes to storage
  always_ff @(posedge clk_i) begin
    nv_we_o <= 1'b0;
    if (reset_i) begin
      cfg_phase_r <= 1'b0;
      cfg_cmd_r <= 8'h00;
      cfg_val_r <= 8'h00;
      cfg_av_r <= 1'b0;
      nv_addr_o <= 8'h00;
      nv_data_o <= 8'h00;
    end else begin
      if (!cfg_mode) begin
        cfg_phase_r <= 1'b0;
      end else if (uart_stb) begin
        cfg_phase_r <= ~cfg_phase_r;
        if (!cfg_phase_r) begin
          cfg_cmd_r <= uart_rx;
        end else begin
          cfg_val_r <= uart_rx;
          nv_addr_o <= cfg_cmd_r;
          nv_data_o <= uart_rx;
          nv_we_o <= 1'b1;
        end
      end
      if (cfg_mode && uart_stb && cfg_phase_r) begin
        cfg_av_r <= 1'b1;
      end else if (rd_i && addr_i == REG_CFG_RD) begin
        cfg_av_r <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Received radio packets
  // ----------------------------------------------------------------
  // Collect dest, cmd, payload, CRC; check and queue for serial output
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rxp_cnt_r <= '0;
      rxp_crc_r <= '0;
      oq_len_r <= '0;
      stat_r <= '0;
    end else begin
      stat_r[STAT_TXBUSY_BIT] <= tx_go_r;
      stat_r[STAT_CFGAV_BIT] <= cfg_av_r;
      if (rd_i && addr_i == REG_STAT) begin
        stat_r[STAT_ACK_BIT] <= 1'b0;
        stat_r[STAT_BAD_BIT] <= 1'b0;
      end
      if (wr_rf_rx && !oq_busy) begin
        if (rxp_cnt_r != 4'hF) begin
          rxp_buf[rxp_cnt_r] <= wdata_i;
          rxp_cnt_r <= rxp_cnt_r + 4'h1;
        end
        rxp_crc_r <= crc8(rxp_crc_r, wdata_i);
      end
      if (wr_rf_end) begin
        rxp_cnt_r <= '0;
        rxp_crc_r <= '0;
        if (rx_good) begin
          stat_r[STAT_ACK_BIT] <= 1'b1;
          for (int i = 0; i < 16; i++) out_q[i] <= rxp_buf[i];
          // Strip mode keeps payload only; packet mode keeps header bytes
          oq_len_r <= 5'(rxp_cnt_r) - 5'h01;
        end else begin
          stat_r[STAT_BAD_BIT] <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Serial output: flow characters take priority over packet bytes
  // ----------------------------------------------------------------
  wire hdr_skip = (mode != MHSP_MODE_PACKET) && (oq_rd_r < 5'h02);
  always_ff @(posedge clk_i) begin
    utx_stb_r <= 1'b0;
    if (reset_i) begin
      oq_rd_r <= '0;
      utx_r <= 8'h00;
      xon_sent_r <= 1'b0;
      xon_want_r <= 1'b1;
    end else begin
      if (sw_flow && (accept != xon_sent_r)) xon_want_r <= 1'b1;
      if (wr_rf_end && rx_good) oq_rd_r <= '0;
      else if (!uart_busy && !utx_stb_r) begin
        if (sw_flow && xon_want_r) begin
          utx_r <= accept ? XON_CHAR : XOFF_CHAR;
          utx_stb_r <= 1'b1;
          xon_sent_r <= accept;
          xon_want_r <= 1'b0;
        end else if (oq_busy) begin
          oq_rd_r <= oq_rd_r + 5'h01;
          if (!hdr_skip) begin
            utx_r <= out_q[oq_rd_r[3:0]];
            utx_stb_r <= 1'b1;
          end
        end
      end
    end
  end
  // Clear-to-send is held high under software flow control
  always_ff @(posedge clk_i) begin
    if (reset_i) cts_n_o <= 1'b1;
    else cts_n_o <= sw_flow | ~accept;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_cts_follows;
    @(posedge clk_i) disable iff (reset_i) !sw_flow && !accept |=> cts_n_o;
  endproperty
  a_cts_follows: assert property (p_cts_follows) else $error("CTS low while not ready");
  property p_drop;
    @(posedge clk_i) disable iff (reset_i) uart_stb && !accept |=> $stable(wp_r);
  endproperty
  a_drop: assert property (p_drop) else $error("Byte taken while not ready");
  property p_tx_start;
    @(posedge clk_i) disable iff (reset_i)
      fsm_r == MHSP_TX_IDLE && (buf_full || timed_out) && !cfg_mode |=> fsm_r == MHSP_TX_PRE;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("Full buffer did not start");
  sequence s_preamble;
    rf_tx_valid_o && rf_tx_data_o == PREAMBLE_BYTE;
  endsequence
  property p_frame;
    @(posedge clk_i) disable iff (reset_i)
      $rose(tx_go_r) |=> s_preamble [*4] ##1 (rf_tx_data_o == SOF_BYTE);
  endproperty
  a_frame: assert property (p_frame) else $error("Frame start wrong");
  property p_cfg_no_data;
    @(posedge clk_i) disable iff (reset_i) cfg_mode && uart_stb |=> $stable(wp_r);
  endproperty
  a_cfg_no_data: assert property (p_cfg_no_data) else $error("Config byte buffered");
  property p_nv;
    @(posedge clk_i) disable iff (reset_i)
      cfg_mode && uart_stb && cfg_phase_r |=> nv_we_o && nv_data_o == $past(uart_rx);
  endproperty
  a_nv: assert property (p_nv) else $error("Config value not stored");
  property p_ack;
    @(posedge clk_i) disable iff (reset_i) rx_good |=> stat_r[STAT_ACK_BIT] && (oq_rd_r == 5'h00);
  endproperty
  a_ack: assert property (p_ack) else $error("No ack on good packet");
  property p_release;
    @(posedge clk_i) disable iff (reset_i)
      fsm_r == MHSP_TX_WAIT && wr_i && addr_i == REG_RF_TX |=> !tx_go_r;
  endproperty
  a_release: assert property (p_release) else $error("Buffer not released");
  property p_timeout;
    @(posedge clk_i) disable iff (reset_i) uart_stb && !cfg_mode |=> idle_r == 0;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Gap timer not restarted");
endmodule
`default_nettype wire

// file: verification/mhsp_host_model.sv
// Host controller model on the far side of the serial port
`timescale 1ns/1ps
`default_nettype none
module mhsp_host_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk_i,
  input wire logic cts_n_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic [7:0] rx_byte_o,
  output logic rx_stb_o
);
  // Line idles high between bytes, as the port expects
  initial begin
    rxd_o = 1'b1;
    rx_stb_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  // One 8N1 byte; ign skips the handshake to provoke a drop
  task automatic send(input logic [7:0] b, input bit ign);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (!ign && cts_n_i !== 1'b0) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask
  // Mid-bit sampling of what the port sends back
  always begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      rx_byte_o[i] <= txd_i;
    end
    repeat (BIT_CYC) @(posedge clk_i);
    rx_stb_o <= 1'b1;
    @(posedge clk_i);
    rx_stb_o <= 1'b0;
  end
endmodule
`default_nettype wire

// file: verification/mhsp_top_test.sv
// Self-checking bench of the mesh host serial port
`timescale 1ns/1ps
`default_nettype none
module mhsp_top_test;
  import mhsp_pkg::*;
  localparam int BC = 8;
  localparam int TO = 2000;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic config_n_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_q = 1'b0;
  logic [15:0] e;
  logic [7:0] b, c;
  logic [16:0] lfsr = 17'h1_18E8;
  logic [15:0] rd_eq[$], rf_q[$], ser_q[$], nv_q[$];
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire logic rxd, txd, cts_n, rf_v, rf_last, nv_we, h_stb;
  wire logic [7:0] rdata, rf_d, nv_a, nv_d, h_byte;
  mhsp_top #(.BUF_DEPTH(256), .TIMEOUT_CYC(TO), .BIT_CYC(BC)) mhsp_top_inst (
    .clk_i(clk_i), .reset_i(reset_i), .rxd_i(rxd), .txd_o(txd), .cts_n_o(cts_n),
    .config_n_i(config_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata), .rf_tx_valid_o(rf_v), .rf_tx_data_o(rf_d),
    .rf_tx_last_o(rf_last), .nv_addr_o(nv_a), .nv_data_o(nv_d), .nv_we_o(nv_we));
  mhsp_host_model #(.BIT_CYC(BC)) mhsp_host_model_inst (
    .clk_i(clk_i), .cts_n_i(cts_n), .txd_i(txd), .rxd_o(rxd),
    .rx_byte_o(h_byte), .rx_stb_o(h_stb));
  initial forever #25 clk_i = ~clk_i;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[7:0];
  endfunction
  // Own CRC-8 step, poly 07, kept apart from the design's
  function automatic logic [7:0] crc_step(input logic [7:0] x, input logic [7:0] d);
    logic [7:0] r;
    r = x ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One bus cycle; strobes stay up for back-to-back calls. e holds {mask, value}
  task automatic bus(input logic w, input logic r, input logic [3:0] a,
                     input logic [7:0] d, input logic [15:0] x);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    if (r) rd_eq.push_back(x);
    @(posedge clk_i);
  endtask
  // Radio packet pushed in over registers, then checked on the host line
  task automatic rx_pkt(input logic [7:0] dst, input bit ok, input bit full, input bit bad);
    logic [7:0] p[5];
    logic [7:0] m;
    m = {6'h00, ~ok, ok};
    p[0] = dst;
    p[4] = 8'h00;
    for (int i = 1; i < 4; i++) p[i] = rnd();
    for (int i = 0; i < 4; i++) p[4] = crc_step(p[4], p[i]);
    p[4] = p[4] ^ {7'h00, bad};
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 1'b0, REG_RF_RX, p[i], 16'h0000);
      if (ok && i < 4 && (full || i > 1)) ser_q.push_back({8'h00, p[i]});
    end
    bus(1'b1, 1'b0, REG_RF_RXEND, 8'h00, 16'h0000);
    bus(1'b0, 1'b0, REG_CTRL, 8'h00, 16'h0000);
    for (int i = 0; i < 3000 && ser_q.size() > 0; i++) @(posedge clk_i);
    repeat (100) @(posedge clk_i);
    check(16'(ser_q.size()), 16'h0000);
    bus(1'b0, 1'b1, REG_STAT, 8'h00, {8'h0F, m});
    bus(1'b0, 1'b0, REG_CTRL, 8'h00, 16'h0000);
  endtask
  // Result watcher: each output event takes the oldest note; empty gives a sentinel
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
    if (rd_q) begin
      e = rd_eq.size() ? rd_eq.pop_front() : 16'h0001;
      check({8'h00, rdata & e[15:8]}, {8'h00, e[7:0]});
    end
    rd_q <= rd_i;
    if (rf_v) check({7'h00, rf_last, rf_d}, rf_q.size() ? rf_q.pop_front() : 16'hFFFF);
    if (h_stb) check({8'h00, h_byte}, ser_q.size() ? ser_q.pop_front() : 16'hFFFF);
    if (nv_we) check({nv_a, nv_d}, nv_q.size() ? nv_q.pop_front() : 16'hFFFF);
  end
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(16'(cts_n), 16'h0000);
    bus(1'b0, 1'b1, REG_CTRL, 8'h00, {8'hFF, CTRL_RST});
    bus(1'b0, 1'b1, REG_MARGIN, 8'h00, 16'hFF12);
    bus(1'b0, 1'b1, 4'hC, 8'h00, 16'hFF00);
    bus(1'b1, 1'b0, REG_TX_CMD, 8'h5A, 16'h0000);
    bus(1'b1, 1'b0, REG_MARGIN, 8'hFD, 16'h0000);
    bus(1'b0, 1'b0, REG_CTRL, 8'h00, 16'h0000);
    // Margin 253 leaves room for three bytes before the port refuses
    c = crc_step(crc_step(8'h00, BCAST_ADDR), 8'h5A);
    for (int i = 0; i < PREAMBLE_LEN; i++) rf_q.push_back({8'h00, PREAMBLE_BYTE});
    rf_q.push_back({8'h00, SOF_BYTE});
    rf_q.push_back({8'h00, BCAST_ADDR});
    rf_q.push_back(16'h005A);
    for (int i = 0; i < 3; i++) begin
      b = rnd();
      c = crc_step(c, b);
      rf_q.push_back({8'h00, b});
      mhsp_host_model_inst.send(b, 1'b0);
    end
    rf_q.push_back({8'h01, c});
    // Fill count moves a cycle after the stop bit, clear-to-send one more
    repeat (3) @(posedge clk_i);
    check(16'(cts_n), 16'h0001);
    mhsp_host_model_inst.send(8'hA5, 1'b1);
    for (int i = 0; i < 5000 && rf_q.size() > 0; i++) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    check(16'(rf_q.size()), 16'h0000);
    check(16'(cts_n), 16'h0001);
    bus(1'b1, 1'b0, REG_RF_TX, 8'h00, 16'h0000);
    bus(1'b0, 1'b0, REG_CTRL, 8'h00, 16'h0000);
    repeat (3) @(posedge clk_i);
    check(16'(cts_n), 16'h0000);
    // Config bytes must reach storage and never the radio
    config_n_i <= 1'b0;
    b = rnd();
    nv_q.push_back({8'h03, b});
    mhsp_host_model_inst.send(8'h03, 1'b1);
    mhsp_host_model_inst.send(b, 1'b1);
    repeat (TO + 200) @(posedge clk_i);
    check(16'(nv_q.size()), 16'h0000);
    bus(1'b0, 1'b1, REG_CFG_RD, 8'h00, 16'hFF03);
    bus(1'b0, 1'b1, REG_NV_SAVE, 8'h00, {8'hFF, b});
    bus(1'b0, 1'b0, REG_CTRL, 8'h00, 16'h0000);
    config_n_i <= 1'b1;
    rx_pkt(8'h33, 1'b0, 1'b0, 1'b0);
    rx_pkt(8'h01, 1'b0, 1'b0, 1'b1);
    rx_pkt(8'h01, 1'b1, 1'b0, 1'b0);
    bus(1'b1, 1'b0, REG_CTRL, 8'h09, 16'h0000);
    rx_pkt(8'hFE, 1'b1, 1'b1, 1'b0);
    rx_pkt(BCAST_ADDR, 1'b1, 1'b1, 1'b0);
    bus(1'b1, 1'b0, REG_CTRL, 8'h0A, 16'h0000);
    rx_pkt(8'h01, 1'b1, 1'b0, 1'b0);
    // Software flow: readiness goes out as Xon, clear-to-send stays high
    ser_q.push_back({8'h00, XON_CHAR});
    bus(1'b1, 1'b0, REG_CTRL, 8'h0C, 16'h0000);
    bus(1'b0, 1'b0, REG_CTRL, 8'h00, 16'h0000);
    for (int i = 0; i < 3000 && ser_q.size() > 0; i++) @(posedge clk_i);
    check(16'(ser_q.size()), 16'h0000);
    check(16'(cts_n), 16'h0001);
    end_of_test();
  end
endmodule
`default_nettype wire
